// ---- hw/rcg_rx_condition_write_guard.v ----
`include "rcg_defs.vh"
`default_nettype none
// Operation
// - reading flag register a copies its current value into snapshot a.
// - writing flag a leaves differing bits untouched and raises write inhibit.
// - reading flag register b copies its current value into snapshot b.
// - writing flag b leaves differing bits untouched and raises write inhibit.
// - snapshot a bits: no-signal up to unknown-line-invalid at the top bit.
// - snapshot b bits: idle-line up to super-idle, top bit reserved.
// - snapshot b bit four mirrors the shared cascade or service event flag.
module rcg_rx_condition_write_guard (
  input wire clk,
  input wire rst_b,
  // control bus, one-cycle strobes on clk
  input wire [7:0] cb_addr,
  input wire cb_rd,
  input wire cb_wr,
  input wire [7:0] cb_wdata,
  output wire [7:0] cb_rdata,
  output wire cb_ack,
  // receive events, set flag register a
  input wire no_signal_set,
  input wire quiet_line_set,
  input wire halt_line_set,
  input wire master_line_set,
  input wire noise_line_set,
  input wire noise_limit_set,
  input wire line_change_set,
  input wire unknown_line_invalid_set,
  // receive events, set flag register b
  input wire idle_line_set,
  input wire line_dwell_limit_set,
  input wire active_line_set,
  input wire unknown_line_valid_set,
  input wire cascade_or_service_event_set,
  input wire elastic_buffer_slip_set,
  input wire super_idle_set,
  // to the interrupt condition register and the rest of the device
  output wire write_inhibit_flag_set,
  output wire [7:0] rx_condition_flags_a,
  output wire [7:0] rx_condition_flags_b,
  output wire [7:0] rx_condition_snapshot_a,
  output wire [7:0] rx_condition_snapshot_b
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire hit_flags_a;
  wire hit_flags_b;
  wire hit_snap_a;
  wire hit_snap_b;
  wire rd_go;
  wire wr_go;
  wire rd_flags_a;
  wire wr_flags_a;
  wire wr_snap_a;
  wire rd_flags_b;
  wire wr_flags_b;
  wire wr_snap_b;
  wire [7:0] set_a;
  wire [7:0] set_b;
  wire [7:0] flags_a_q;
  wire [7:0] flags_b_q;
  wire [7:0] snap_a_q;
  wire [7:0] snap_b_q;
  wire inhibit_a;
  wire inhibit_b;
  wire inhibit_any;
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;
  reg ack_r;
  reg inhibit_r;

  assign hit_flags_a = (cb_addr == `RCG_ADDR_FLAGS_A);
  assign hit_flags_b = (cb_addr == `RCG_ADDR_FLAGS_B);
  assign hit_snap_a = (cb_addr == `RCG_ADDR_SNAP_A);
  assign hit_snap_b = (cb_addr == `RCG_ADDR_SNAP_B);
  // a read and a write in one cycle: the read is served, the write dropped
  assign rd_go = cb_rd;
  assign wr_go = cb_wr & ~cb_rd;

  // ------------------------------------------------------------
  // per-register strobes
  // ------------------------------------------------------------
  // a read of flags a also loads snapshot a
  assign rd_flags_a = rd_go & hit_flags_a;
  // a write of flags a is guarded bit by bit
  assign wr_flags_a = wr_go & hit_flags_a;
  // snapshot a takes a write directly
  assign wr_snap_a = wr_go & hit_snap_a;
  // a read of flags b also loads snapshot b
  assign rd_flags_b = rd_go & hit_flags_b;
  // a write of flags b is guarded bit by bit
  assign wr_flags_b = wr_go & hit_flags_b;
  // snapshot b takes a write directly
  assign wr_snap_b = wr_go & hit_snap_b;

  // ------------------------------------------------------------
  // event bit placement
  // ------------------------------------------------------------
  // layout of registers a and b
  assign set_a[`RCG_A_NO_SIGNAL] = no_signal_set;
  assign set_a[`RCG_A_QUIET_LINE] = quiet_line_set;
  assign set_a[`RCG_A_HALT_LINE] = halt_line_set;
  assign set_a[`RCG_A_MASTER_LINE] = master_line_set;
  assign set_a[`RCG_A_NOISE_LINE] = noise_line_set;
  assign set_a[`RCG_A_NOISE_LIMIT] = noise_limit_set;
  assign set_a[`RCG_A_LINE_CHANGE] = line_change_set;
  assign set_a[`RCG_A_UNKNOWN_INVALID] = unknown_line_invalid_set;
  assign set_b[`RCG_B_IDLE_LINE] = idle_line_set;
  assign set_b[`RCG_B_DWELL_LIMIT] = line_dwell_limit_set;
  assign set_b[`RCG_B_ACTIVE_LINE] = active_line_set;
  assign set_b[`RCG_B_UNKNOWN_VALID] = unknown_line_valid_set;
  // one shared flag, meaning chosen by operating mode elsewhere
  assign set_b[`RCG_B_CASCADE_SERVICE] = cascade_or_service_event_set;
  assign set_b[`RCG_B_BUFFER_SLIP] = elastic_buffer_slip_set;
  assign set_b[`RCG_B_SUPER_IDLE] = super_idle_set;
  // reserved bit is never set by hardware and reads zero in the flags
  assign set_b[`RCG_B_RESERVED] = 1'b0;

  // ------------------------------------------------------------
  // guarded flag registers
  // ------------------------------------------------------------
  // snapshot a on read, guarded write of a, snapshot a direct
  rcg_guard_reg #(
    .WIDTH(8),
    .MASK(`RCG_MASK_A),
    .RST_FLAGS(`RCG_RST_FLAGS),
    .RST_SNAP(`RCG_RST_SNAP)
  ) u_guard_a (
    .clk(clk),
    .rst_b(rst_b),
    .hw_set(set_a),
    .rd_flag(rd_flags_a),
    .wr_flag(wr_flags_a),
    .wr_snap(wr_snap_a),
    .wdata(cb_wdata),
    .flag_q(flags_a_q),
    .snap_q(snap_a_q),
    .inhibit(inhibit_a)
  );

  // snapshot b on read, guarded write of b, snapshot b direct
  rcg_guard_reg #(
    .WIDTH(8),
    .MASK(`RCG_MASK_B),
    .RST_FLAGS(`RCG_RST_FLAGS),
    .RST_SNAP(`RCG_RST_SNAP)
  ) u_guard_b (
    .clk(clk),
    .rst_b(rst_b),
    .hw_set(set_b),
    .rd_flag(rd_flags_b),
    .wr_flag(wr_flags_b),
    .wr_snap(wr_snap_b),
    .wdata(cb_wdata),
    .flag_q(flags_b_q),
    .snap_q(snap_b_q),
    .inhibit(inhibit_b)
  );

  // ------------------------------------------------------------
  // read data and answer
  // ------------------------------------------------------------
  always @* begin
    rdata_nxt = rdata_r;
    if (rd_go) begin
      case (1'b1)
        hit_flags_a: rdata_nxt = flags_a_q;
        hit_flags_b: rdata_nxt = flags_b_q;
        hit_snap_a: rdata_nxt = snap_a_q;
        hit_snap_b: rdata_nxt = snap_b_q;
        default: rdata_nxt = `RCG_RST_RDATA;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read data register
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= `RCG_RST_RDATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------
  // unmapped accesses are answered too, so the host never waits forever
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= rd_go | wr_go;
    end
  end

  // ------------------------------------------------------------
  // write inhibit pulse
  // ------------------------------------------------------------
  // rejected write of a or b
  assign inhibit_any = inhibit_a | inhibit_b;
  // one pulse per rejected access; the interrupt register keeps the level
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inhibit_r <= 1'b0;
    end else begin
      inhibit_r <= inhibit_any;
    end
  end

  assign cb_rdata = rdata_r;
  assign cb_ack = ack_r;
  assign write_inhibit_flag_set = inhibit_r;
  assign rx_condition_flags_a = flags_a_q;
  assign rx_condition_flags_b = flags_b_q;
  assign rx_condition_snapshot_a = snap_a_q;
  assign rx_condition_snapshot_b = snap_b_q;
endmodule // rcg_rx_condition_write_guard
`default_nettype wire

// ---- include/rcg_defs.vh ----
`ifndef RCG_DEFS_VH
`define RCG_DEFS_VH
// ------------------------------------------------------------
// control bus offsets
// ------------------------------------------------------------
`define RCG_ADDR_FLAGS_A 8'h0e
`define RCG_ADDR_FLAGS_B 8'h0f
`define RCG_ADDR_SNAP_A 8'h1c
`define RCG_ADDR_SNAP_B 8'h1d
// ------------------------------------------------------------
// flag register a fields
// ------------------------------------------------------------
`define RCG_A_NO_SIGNAL 0
`define RCG_A_QUIET_LINE 1
`define RCG_A_HALT_LINE 2
`define RCG_A_MASTER_LINE 3
`define RCG_A_NOISE_LINE 4
`define RCG_A_NOISE_LIMIT 5
`define RCG_A_LINE_CHANGE 6
`define RCG_A_UNKNOWN_INVALID 7
// ------------------------------------------------------------
// flag register b fields
// ------------------------------------------------------------
`define RCG_B_IDLE_LINE 0
`define RCG_B_DWELL_LIMIT 1
`define RCG_B_ACTIVE_LINE 2
`define RCG_B_UNKNOWN_VALID 3
`define RCG_B_CASCADE_SERVICE 4
`define RCG_B_BUFFER_SLIP 5
`define RCG_B_SUPER_IDLE 6
`define RCG_B_RESERVED 7
// ------------------------------------------------------------
// implemented bits and reset values
// ------------------------------------------------------------
`define RCG_MASK_A 8'hff
`define RCG_MASK_B 8'h7f
`define RCG_RST_FLAGS 8'h00
`define RCG_RST_SNAP 8'h00
`define RCG_RST_RDATA 8'h00
`endif

// ---- hw/rcg_guard_reg.v ----
`default_nettype none
module rcg_guard_reg #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] MASK = {WIDTH{1'b1}},
  parameter [WIDTH-1:0] RST_FLAGS = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] RST_SNAP = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] hw_set,
  input wire rd_flag,
  input wire wr_flag,
  input wire wr_snap,
  input wire [WIDTH-1:0] wdata,
  output wire [WIDTH-1:0] flag_q,
  output wire [WIDTH-1:0] snap_q,
  output wire inhibit
);
  reg [WIDTH-1:0] flag_r;
  reg [WIDTH-1:0] flag_nxt;
  reg [WIDTH-1:0] snap_r;
  reg [WIDTH-1:0] snap_nxt;
  wire [WIDTH-1:0] differ;

  assign differ = (flag_r ^ snap_r) & MASK;
  assign inhibit = wr_flag & (|differ);
  assign flag_q = flag_r;
  assign snap_q = snap_r;

  always @* begin
    flag_nxt = flag_r;
    if (wr_flag) begin
      // bits that disagree keep their value; equal bits take the write
      flag_nxt = (flag_r & differ) | (wdata & ~differ);
    end
    // a receive event in the same cycle as a clear still lands
    flag_nxt = (flag_nxt | hw_set) & MASK;
  end

  always @* begin
    snap_nxt = snap_r;
    if (rd_flag) begin
      snap_nxt = flag_r;
    end else if (wr_snap) begin
      snap_nxt = wdata;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= RST_FLAGS;
      snap_r <= RST_SNAP;
    end else begin
      flag_r <= flag_nxt;
      snap_r <= snap_nxt;
    end
  end
endmodule // rcg_guard_reg
`default_nettype wire

// ---- verification/rcg_host_model.sv ----
`default_nettype none
module rcg_host_model (
  input wire logic clk,
  output logic [7:0] cb_addr,
  output logic cb_rd,
  output logic cb_wr,
  output logic [7:0] cb_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cb_addr = 8'h00;
    cb_rd = 1'b0;
    cb_wr = 1'b0;
    cb_wdata = 8'h00;
  end
  // one-cycle strobe; returns in the cycle that carries the answer
  task automatic access(input logic [7:0] a, input logic rd, input logic [7:0] d);
    @(negedge clk);
    cb_addr = a;
    cb_rd = rd;
    cb_wr = !rd;
    cb_wdata = d;
    @(negedge clk);
    cb_rd = 1'b0;
    cb_wr = 1'b0;
    // stale data would hide a late sample
    cb_wdata = ~d;
  endtask
endmodule // rcg_host_model
`default_nettype wire

// ---- verification/rcg_guard_asserts.sv ----
`include "rcg_defs.vh"
`default_nettype none
module rcg_guard_asserts (
  input wire clk,
  input wire rst_b,
  input wire [7:0] cb_addr,
  input wire cb_rd,
  input wire cb_wr,
  input wire [7:0] cb_wdata,
  input wire [7:0] cb_rdata,
  input wire cb_ack,
  input wire write_inhibit_flag_set,
  input wire [7:0] rx_condition_flags_a,
  input wire [7:0] rx_condition_flags_b,
  input wire [7:0] rx_condition_snapshot_a,
  input wire [7:0] rx_condition_snapshot_b
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [7:0] fa = rx_condition_flags_a;
  wire [7:0] fb = rx_condition_flags_b;
  wire [7:0] sa = rx_condition_snapshot_a;
  wire [7:0] sb = rx_condition_snapshot_b;
  wire inh = write_inhibit_flag_set;
  wire wr = cb_wr && !cb_rd;
  wire wr_a = wr && cb_addr == `RCG_ADDR_FLAGS_A;
  wire wr_b = wr && cb_addr == `RCG_ADDR_FLAGS_B;
  wire [7:0] dif_b = (fb ^ sb) & `RCG_MASK_B;
  wire rejected = (wr_a && fa != sa) || (wr_b && dif_b != 8'h00);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  snap_copy_a: assert property (cb_rd && cb_addr == `RCG_ADDR_FLAGS_A |=> sa == $past(fa))
    else $error("snapshot a not loaded");
  snap_copy_b: assert property (cb_rd && cb_addr == `RCG_ADDR_FLAGS_B |=> sb == $past(fb))
    else $error("snapshot b not loaded");
  read_data_b: assert property (cb_rd && cb_addr == `RCG_ADDR_FLAGS_B |=> cb_rdata == $past(fb))
    else $error("flags b read wrong");
  inhibit_a: assert property (wr_a && fa != sa |=> inh)
    else $error("no inhibit on a");
  inhibit_b: assert property (wr_b && dif_b != 8'h00 |=> inh)
    else $error("no inhibit on b");
  keep_bits_a: assert property (wr_a |=> ($past(fa & (fa ^ sa)) & ~fa) == 8'h00)
    else $error("blocked bit cleared");
  reserved_b_a: assert property (fb[7] == 1'b0)
    else $error("reserved bit set");
  snap_write_a: assert property (wr && cb_addr == `RCG_ADDR_SNAP_A |=> sa == $past(cb_wdata))
    else $error("snapshot a write lost");
  no_false_a: assert property (wr && fa == sa && dif_b == 8'h00 |=> !inh)
    else $error("spurious inhibit");
  ack_timing_a: assert property (cb_ack == $past(cb_rd || cb_wr))
    else $error("bus answer mistimed");
  inhibit_exact_a: assert property (inh == $past(rejected))
    else $error("inhibit pulse mistimed");
  cover property (wr_a && fa != sa);
  cover property (wr_b && dif_b != 8'h00);
  cover property (cb_rd && cb_addr == `RCG_ADDR_FLAGS_B);
endmodule // rcg_guard_asserts
bind rcg_rx_condition_write_guard rcg_guard_asserts rcg_guard_asserts_i (.clk, .rst_b,
  .cb_addr, .cb_rd, .cb_wr, .cb_wdata, .cb_rdata, .cb_ack, .write_inhibit_flag_set,
  .rx_condition_flags_a, .rx_condition_flags_b, .rx_condition_snapshot_a,
  .rx_condition_snapshot_b);
`default_nettype wire

// ---- verification/rcg_rx_condition_write_guard_tb.sv ----
`include "rcg_defs.vh"
`default_nettype none
module rcg_rx_condition_write_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [14:0] ev = 15'h0000;
  wire [7:0] cb_addr, cb_wdata, cb_rdata, fa, fb, sa, sb;
  wire cb_rd, cb_wr, cb_ack, inh;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  rcg_host_model rcg_host_model_i (.clk, .cb_addr, .cb_rd, .cb_wr, .cb_wdata);
  rcg_rx_condition_write_guard rcg_rx_condition_write_guard_i (
    .clk, .rst_b, .cb_addr, .cb_rd, .cb_wr, .cb_wdata, .cb_rdata, .cb_ack,
    .no_signal_set(ev[0]), .quiet_line_set(ev[1]), .halt_line_set(ev[2]),
    .master_line_set(ev[3]), .noise_line_set(ev[4]), .noise_limit_set(ev[5]),
    .line_change_set(ev[6]), .unknown_line_invalid_set(ev[7]), .idle_line_set(ev[8]),
    .line_dwell_limit_set(ev[9]), .active_line_set(ev[10]), .unknown_line_valid_set(ev[11]),
    .cascade_or_service_event_set(ev[12]), .elastic_buffer_slip_set(ev[13]),
    .super_idle_set(ev[14]), .write_inhibit_flag_set(inh), .rx_condition_flags_a(fa),
    .rx_condition_flags_b(fb), .rx_condition_snapshot_a(sa), .rx_condition_snapshot_b(sb));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rcg_host_model_i.access(a, 1'b1, 8'h00);
    chk("ack", 8'h01, {7'h00, cb_ack});
    chk("rdata", e, cb_rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e);
    rcg_host_model_i.access(a, 1'b0, d);
    chk("inhibit", {7'h00, e}, {7'h00, inh});
  endtask
  task automatic pulse(input int i);
    @(negedge clk);
    ev[i] = 1'b1;
    @(negedge clk);
    ev[i] = 1'b0;
  endtask
  task automatic end_sim;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_sim;
    end
  end
  initial begin
    logic [7:0] a;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    rd(`RCG_ADDR_SNAP_B, 8'h00);
    rd(8'h00, 8'h00);
    // every event bit: read copies, then a matching clear is taken
    for (int i = 0; i < 15; i++) begin
      a = (i < 8) ? `RCG_ADDR_FLAGS_A : `RCG_ADDR_FLAGS_B;
      pulse(i);
      rd(a, 8'h01 << (i % 8));
      rd(a + 8'h0e, 8'h01 << (i % 8));
      wr(a, 8'h00, 1'b0);
      rd(a, 8'h00);
    end
    // unread event blocks its bit, matching bit still written
    for (int j = 0; j < 2; j++) begin
      a = `RCG_ADDR_FLAGS_A + j[7:0];
      pulse(j * 8 + 5);
      wr(a, 8'h01, 1'b1);
      rd(a, 8'h21);
      wr(a, 8'h00, 1'b0);
      rd(a, 8'h00);
    end
    wr(`RCG_ADDR_SNAP_A, 8'ha5, 1'b0);
    rd(`RCG_ADDR_SNAP_A, 8'ha5);
    wr(`RCG_ADDR_FLAGS_A, 8'hff, 1'b1);
    rd(`RCG_ADDR_FLAGS_A, 8'h5a);
    wr(`RCG_ADDR_SNAP_B, 8'h96, 1'b0);
    rd(`RCG_ADDR_SNAP_B, 8'h96);
    wr(`RCG_ADDR_FLAGS_B, 8'hff, 1'b1);
    rd(`RCG_ADDR_FLAGS_B, 8'h69);
    end_sim;
  end
endmodule // rcg_rx_condition_write_guard_tb
`default_nettype wire
